/* File: hw/ebb_bridge.sv */
// Purpose: AXI4-Lite slave to external peripheral bus bridge
// Assumes: AXI on ref_clk; peripheral pins asynchronous
// Notes: Peripheral data bus is labelled big-endian [0:31]
// Function
// - Active-low chip select, high after reset
// - Active-high address strobe, low after reset
// - Sync mode read-not-write output, rests high
// - Async mode separate low read, write strobes
// - Active-high burst output, low after reset
// - Peripheral stretches access through ready input
// - FIFO access keeps address fixed
// - FIFO sub-transfers never advance the address
// - Ready wait timeout aborts with slave error
// - Finish cycle after ready seen, or on timeout or reset abort
// - Every narrow sub-transfer checks ready again
// - Both ready counters start at strobe edge
// - Late ready waits until maximum wait
// - Reset returns access machine to idle
// - Data bus bit 0 is most significant
// - Narrow peripherals use lanes from bit 0
// - Separate address and data: strobe stays low
// - Read-not-write high for read, low write
// - Byte enables are active high
// - Sync multiplexed access asserts select twice
`include "ebb_regs.svh"

module ebb_bridge
  import ebb_pkg::*;
#(
  parameter int NUM_DEV = 4,
  parameter int PA_WIDTH = 16,
  parameter int AD_WIDTH = 32
)(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // AXI4-Lite write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-device configuration
  input wire logic [NUM_DEV-1:0] cfg_sync_mode,
  input wire logic [NUM_DEV-1:0] cfg_mux_mode,
  input wire logic [NUM_DEV-1:0] cfg_width_match,
  input wire logic [NUM_DEV-1:0][1:0] cfg_periph_width,
  input wire logic cfg_fifo_en,
  input wire logic [PA_WIDTH-1:0] cfg_fifo_addr,
  // Status
  output logic busy,
  output logic late_ready,
  // Peripheral pins
  input wire logic prh_clk,
  input wire logic prh_rst,
  input wire logic prh_rdy,
  input wire logic [0:AD_WIDTH-1] prh_data_i,
  output logic [NUM_DEV-1:0] prh_cs_n,
  output logic [PA_WIDTH-1:0] prh_addr,
  output logic prh_ads,
  output logic [0:`EBB_LANES-1] periph_byte_enables,
  output logic prh_rnw,
  output logic prh_rd_n,
  output logic prh_wr_n,
  output logic prh_burst,
  output logic [0:AD_WIDTH-1] prh_data_o,
  output logic prh_data_oe
);

  localparam int SW = AD_WIDTH + 3;
  localparam int BW = `EBB_BYTE_W;

  initial
  begin
    if (NUM_DEV < 1 || NUM_DEV > 4)
      $error("ebb_bridge: NUM_DEV must be 1 to 4");
    if (AD_WIDTH != `EBB_AXI_DW)
      $error("ebb_bridge: AD_WIDTH must be 32");
    if (PA_WIDTH < 3 || PA_WIDTH > 32)
      $error("ebb_bridge: PA_WIDTH must be 3 to 32");
  end

  // Pin inputs through two flops
  logic [SW-1:0] sync_q;  // Synchronised pin levels
  ebb_sync #(.W(SW)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .din({prh_clk, prh_rst, prh_rdy, prh_data_i}),
    .dout(sync_q)
  );
  wire pclk_s = sync_q[SW-1];
  wire prst_s = sync_q[SW-2];
  wire rdy_s = sync_q[SW-3];
  wire [0:AD_WIDTH-1] din_s = sync_q[AD_WIDTH-1:0];

  // Ready counters
  ebb_tmr_if tif ();
  ebb_rdy_timer #(
    .RV_CYC(`EBB_RDY_VALID_CYC),
    .MAX_CYC(`EBB_MAX_RDY_CYC)
  ) u_tmr (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .t(tif)
  );

  // Sequencer state
  ebb_state_e st_r, st_nxt;         // Access state
  logic [7:0] cnt_r, cnt_nxt;       // Phase counter
  logic [1:0] beat_r, beat_nxt;     // Sub-transfer index
  logic [1:0] dev_r, dev_nxt;       // Addressed device
  logic rnw_r, rnw_nxt;             // Read access
  logic [PA_WIDTH-1:0] addr_r, addr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic fifo_r, fifo_nxt;           // FIFO address hit
  logic [31:0] rdata_r, rdata_nxt;
  ebb_resp_e resp_r, resp_nxt;
  logic pclk_d_r;                   // Previous sync'd link clock
  logic late_nxt;

  // Link clock rising edge paces sync mode
  wire pclk_rise = pclk_s & ~pclk_d_r;

  // Configuration of the current and next device
  wire sync_c = cfg_sync_mode[dev_r];
  wire sync_n = cfg_sync_mode[dev_nxt];
  wire mux_c = cfg_mux_mode[dev_r];
  wire mux_n = cfg_mux_mode[dev_nxt];
  wire [1:0] pw_c = cfg_periph_width[dev_r];
  wire [1:0] pw_n = cfg_periph_width[dev_nxt];
  wire tick = sync_c ? pclk_rise : 1'b1;

  // Bytes per sub-transfer
  wire [2:0] w_c = (pw_c == PW_8) ? 3'h1 : (pw_c == PW_16) ? 3'h2 : 3'h4;
  wire [2:0] w_n = (pw_n == PW_8) ? 3'h1 : (pw_n == PW_16) ? 3'h2 : 3'h4;
  // Last sub-transfer index with width matching on
  wire [1:0] last_c = !cfg_width_match[dev_r] ? 2'h0 :
                      (pw_c == PW_8) ? 2'h3 :
                      (pw_c == PW_16) ? 2'h1 : 2'h0;
  wire [1:0] last_n = !cfg_width_match[dev_nxt] ? 2'h0 :
                      (pw_n == PW_8) ? 2'h3 :
                      (pw_n == PW_16) ? 2'h1 : 2'h0;

  // Phase lengths in ticks
  wire [7:0] setup_len = sync_c ? 8'(`EBB_SYNC_PHASE_CYC) :
                                  8'(`EBB_SETUP_CYC);
  wire [7:0] strb_len = sync_c ? 8'(`EBB_SYNC_PHASE_CYC) :
                                 8'(`EBB_STRB_CYC);
  wire [7:0] recov_len = sync_c ? 8'(`EBB_SYNC_PHASE_CYC) :
                                  8'(`EBB_RECOV_CYC);

  // Request decode
  wire [1:0] aw_dev = s_axi_awaddr[`EBB_DEV_LSB +: `EBB_DEV_W];
  wire [1:0] ar_dev = s_axi_araddr[`EBB_DEV_LSB +: `EBB_DEV_W];
  wire take_w = s_axi_awvalid & s_axi_wvalid;
  wire take_r = s_axi_arvalid & ~take_w;
  wire [1:0] req_dev = take_w ? aw_dev : ar_dev;
  wire [PA_WIDTH-1:0] req_addr = take_w ? s_axi_awaddr[PA_WIDTH-1:0] :
                                          s_axi_araddr[PA_WIDTH-1:0];
  wire req_ok = (32'(req_dev) < 32'(NUM_DEV));
  wire start_ok = (st_r == ST_IDLE) & (take_w | take_r);

  // Strobe phase outcome
  wire strb_done = (cnt_r >= strb_len);
  wire rdy_hit = strb_done & rdy_s & tick;
  wire abort = tif.timeout | prst_s;

  // Byte offsets of current and next sub-transfer
  wire [2:0] base_c = 3'(beat_r * w_c);
  wire [2:0] base_n = 3'(beat_nxt * w_n);
  logic [31:0] rd_merge;  // Read word with this beat's lanes merged

  // Read lanes land at their big-endian AXI byte position
  genvar j;
  generate
    for (j = 0; j < `EBB_LANES; j++)
    begin : g_rd
      wire [2:0] off = 3'(j) - base_c;
      wire hit = (3'(j) >= base_c) && (off < w_c);
      assign rd_merge[BW*(`EBB_LANES-1-j) +: BW] =
        hit ? din_s[BW*off[1:0] +: BW] :
              rdata_r[BW*(`EBB_LANES-1-j) +: BW];
    end
  endgenerate

  // Next-state logic of the access sequencer
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    beat_nxt = beat_r;
    dev_nxt = dev_r;
    rnw_nxt = rnw_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    fifo_nxt = fifo_r;
    rdata_nxt = rdata_r;
    resp_nxt = resp_r;
    late_nxt = late_ready;
    case (st_r)
      ST_IDLE:
      begin
        // Capture a request; writes take precedence
        if (start_ok)
        begin
          dev_nxt = req_dev;
          rnw_nxt = ~take_w;
          addr_nxt = req_addr;
          wdata_nxt = s_axi_wdata;
          wstrb_nxt = s_axi_wstrb;
          fifo_nxt = cfg_fifo_en & (req_addr == cfg_fifo_addr);
          rdata_nxt = '0;
          beat_nxt = 2'h0;
          cnt_nxt = 8'h00;
          late_nxt = 1'b0;
          resp_nxt = req_ok ? RESP_OKAY : RESP_DECERR;
          st_nxt = req_ok ? ST_SETUP : ST_RESP;
        end
      end
      ST_SETUP:
      begin
        // Address phase
        if (tick)
          cnt_nxt = cnt_r + 8'h01;
        if (tick && cnt_nxt >= setup_len)
        begin
          cnt_nxt = 8'h00;
          st_nxt = mux_c ? ST_GAP : ST_STRB;
        end
      end
      ST_GAP:
      begin
        // Select drops between address and data phases
        if (tick)
          st_nxt = ST_STRB;
      end
      ST_STRB:
      begin
        // Hold until ready, or give up at the maximum wait
        if (tick && !strb_done)
          cnt_nxt = cnt_r + 8'h01;
        if (abort)
        begin
          resp_nxt = RESP_SLVERR;
          cnt_nxt = 8'h00;
          st_nxt = ST_RECOV;
        end
        else if (rdy_hit)
        begin
          if (rnw_r)
            rdata_nxt = rd_merge;
          late_nxt = late_ready | tif.rv_over;
          cnt_nxt = 8'h00;
          st_nxt = ST_RECOV;
        end
      end
      ST_RECOV:
      begin
        // Recovery, then next sub-transfer or answer
        if (tick)
          cnt_nxt = cnt_r + 8'h01;
        if (tick && cnt_nxt >= recov_len)
        begin
          cnt_nxt = 8'h00;
          if (beat_r != last_c && resp_r == RESP_OKAY)
          begin
            beat_nxt = beat_r + 2'h1;
            st_nxt = ST_SETUP;
          end
          else
            st_nxt = ST_RESP;
        end
      end
      ST_RESP:
      begin
        // Answer held until the master takes it
        if ((rnw_r && s_axi_rready) || (!rnw_r && s_axi_bready))
          st_nxt = ST_IDLE;
      end
      default:
        st_nxt = ST_IDLE;
    endcase
  end

  // Pin levels decoded from the next state
  wire act_n = (st_nxt == ST_SETUP) | (st_nxt == ST_GAP) |
               (st_nxt == ST_STRB) | (st_nxt == ST_RECOV);
  wire cs_on = ((st_nxt == ST_SETUP) | (st_nxt == ST_STRB)) &
               (resp_nxt == RESP_OKAY);
  wire ads_on = (st_nxt == ST_SETUP) & mux_n;
  wire strb_on = (st_nxt == ST_STRB) & ~sync_n;
  wire oe_on = ~rnw_nxt & ((st_nxt == ST_STRB) |
               ((st_nxt == ST_SETUP) & ~mux_n));
  wire burst_on = act_n & (beat_nxt != last_n);
  wire [PA_WIDTH-1:0] paddr_n = fifo_nxt ? addr_nxt :
                                addr_nxt + PA_WIDTH'(base_n);

  // Write lanes and byte enables from big-endian AXI bytes
  logic [0:AD_WIDTH-1] pdo_n;      // Data lanes for next beat
  logic [0:`EBB_LANES-1] pbe_n;    // Byte enables for next beat
  logic [NUM_DEV-1:0] cs_n_n;      // Select pins for next beat
  genvar i;
  generate
    for (i = 0; i < `EBB_LANES; i++)
    begin : g_wr
      wire [2:0] src = base_n + 3'(i);
      wire on = (3'(i) < w_n) & act_n;
      assign pdo_n[BW*i +: BW] = on ?
        wdata_nxt[BW*(`EBB_LANES-1-src[1:0]) +: BW] : '0;
      assign pbe_n[i] = on & wstrb_nxt[`EBB_LANES-1-src[1:0]];
    end
    for (i = 0; i < NUM_DEV; i++)
    begin : g_cs
      assign cs_n_n[i] = ~(cs_on & (dev_nxt == 2'(i)));
    end
  endgenerate

  // Timer handshakes on strobe entry and exit
  assign tif.start = (st_r != ST_STRB) & (st_nxt == ST_STRB);
  assign tif.stop = (st_r == ST_STRB) & (st_nxt != ST_STRB);
  assign tif.rdy = rdy_s;

  // Sequencer registers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      st_r <= ST_IDLE;
      cnt_r <= 8'h00;
      beat_r <= 2'h0;
      dev_r <= 2'h0;
      rnw_r <= 1'b1;
      addr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      fifo_r <= 1'b0;
      rdata_r <= '0;
      resp_r <= RESP_OKAY;
      pclk_d_r <= 1'b0;
      late_ready <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      beat_r <= beat_nxt;
      dev_r <= dev_nxt;
      rnw_r <= rnw_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      fifo_r <= fifo_nxt;
      rdata_r <= rdata_nxt;
      resp_r <= resp_nxt;
      pclk_d_r <= pclk_s;
      late_ready <= late_nxt;
    end
  end

  // Output registers for pins and AXI answers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      prh_cs_n <= {NUM_DEV{`EBB_CS_REST}};
      prh_ads <= `EBB_ADS_REST;
      prh_rnw <= `EBB_RNW_REST;
      prh_rd_n <= `EBB_STRB_REST;
      prh_wr_n <= `EBB_STRB_REST;
      prh_burst <= `EBB_BURST_REST;
      prh_addr <= '0;
      periph_byte_enables <= '0;
      prh_data_o <= '0;
      prh_data_oe <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      busy <= 1'b0;
    end
    else if (clk_en)
    begin
      prh_cs_n <= cs_n_n;
      prh_ads <= ads_on;
      prh_rnw <= act_n ? rnw_nxt : `EBB_RNW_REST;
      prh_rd_n <= ~(strb_on & rnw_nxt);
      prh_wr_n <= ~(strb_on & ~rnw_nxt);
      prh_burst <= burst_on;
      prh_addr <= act_n ? paddr_n : '0;
      periph_byte_enables <= pbe_n;
      prh_data_o <= oe_on ? pdo_n : '0;
      prh_data_oe <= oe_on;
      s_axi_awready <= start_ok & take_w;
      s_axi_wready <= start_ok & take_w;
      s_axi_arready <= start_ok & take_r;
      s_axi_bvalid <= (st_nxt == ST_RESP) & ~rnw_nxt;
      s_axi_rvalid <= (st_nxt == ST_RESP) & rnw_nxt;
      s_axi_bresp <= resp_nxt;
      s_axi_rresp <= resp_nxt;
      s_axi_rdata <= rdata_nxt;
      busy <= st_nxt != ST_IDLE;
    end
  end

endmodule : ebb_bridge

/* File: hw/ebb_pkg.sv */
// Purpose: Types shared by the bridge modules
// Assumes: Constants live in ebb_regs.svh
// Notes: Binary state codes are written out
package ebb_pkg;

  // Access state machine
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_SETUP = 3'h1,
    ST_GAP   = 3'h2,
    ST_STRB  = 3'h3,
    ST_RECOV = 3'h4,
    ST_RESP  = 3'h5
  } ebb_state_e;

  // AXI response codes
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2,
    RESP_DECERR = 2'h3
  } ebb_resp_e;

  // Peripheral data width codes
  typedef enum logic [1:0] {
    PW_8  = 2'h0,
    PW_16 = 2'h1,
    PW_32 = 2'h2
  } ebb_pw_e;

endpackage : ebb_pkg

/* File: hw/ebb_rdy_timer.sv */
// Purpose: Ready-valid and maximum-wait counters
// Assumes: start pulses in the cycle the strobe goes active
// Notes: Counts ref_clk cycles in every mode
module ebb_rdy_timer #(
  parameter int RV_CYC = 3,
  parameter int MAX_CYC = 12
)(
  // Clock and control
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Sequencer link
  ebb_tmr_if.tmr t
);

  localparam int CW = $clog2(MAX_CYC + 1);

  initial
  begin
    if (RV_CYC < 1 || RV_CYC >= MAX_CYC)
      $error("ebb_rdy_timer: need 1 <= RV_CYC < MAX_CYC");
  end

  logic [CW-1:0] cnt_r;  // Ready-low cycles since strobe went active
  logic run_r;           // Counting
  logic rv_over_r;       // Ready late
  logic timeout_r;       // Waited too long

  wire rv_hit = (cnt_r == CW'(RV_CYC - 1));
  wire max_hit = (cnt_r == CW'(MAX_CYC - 1));

  // Both counters start together on the strobe edge
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      run_r <= 1'b0;
      rv_over_r <= 1'b0;
      timeout_r <= 1'b0;
    end
    else if (clk_en)
    begin
      if (t.start)
      begin
        cnt_r <= '0;
        run_r <= 1'b1;
        rv_over_r <= 1'b0;
        timeout_r <= 1'b0;
      end
      else if (t.stop)
        run_r <= 1'b0;
      else if (run_r && !t.rdy)
      begin
        cnt_r <= cnt_r + CW'(1);
        // Late ready keeps the wait going
        if (rv_hit)
          rv_over_r <= 1'b1;
        if (max_hit)
        begin
          timeout_r <= 1'b1;
          run_r <= 1'b0;
        end
      end
    end
  end

  assign t.rv_over = rv_over_r;
  assign t.timeout = timeout_r;

endmodule : ebb_rdy_timer

/* File: hw/ebb_regs.svh */
// Purpose: Named constants for the peripheral bus bridge
// Assumes: 250 MHz ref_clk, times given in picoseconds
// Notes: Cycle counts are derived here from the printed times
`ifndef EBB_REGS_SVH
`define EBB_REGS_SVH

// Clock period and peripheral timing, in ps
`define EBB_CLK_PS 4000
`define EBB_ADDR_SETUP_PS 6000
`define EBB_STRB_WIDTH_PS 15000
`define EBB_CYCLE_PS 30000
`define EBB_RDY_VALID_PS 10000
`define EBB_MAX_RDY_PS 50000

// Least times round up, longest times round down
`define EBB_CEIL(t) (((t) + `EBB_CLK_PS - 1) / `EBB_CLK_PS)
`define EBB_SETUP_CYC `EBB_CEIL(`EBB_ADDR_SETUP_PS)
`define EBB_STRB_CYC `EBB_CEIL(`EBB_STRB_WIDTH_PS)
`define EBB_RECOV_CYC `EBB_CEIL(`EBB_CYCLE_PS - `EBB_STRB_WIDTH_PS)
`define EBB_RDY_VALID_CYC `EBB_CEIL(`EBB_RDY_VALID_PS)
`define EBB_MAX_RDY_CYC (`EBB_MAX_RDY_PS / `EBB_CLK_PS)
`define EBB_SYNC_PHASE_CYC 1

// Device select field in the AXI address
`define EBB_DEV_LSB 28
`define EBB_DEV_W 2

// Byte lanes of the data word
`define EBB_LANES 4
`define EBB_BYTE_W 8
`define EBB_AXI_DW 32

// Pin levels while idle and after reset
`define EBB_CS_REST 1'b1
`define EBB_ADS_REST 1'b0
`define EBB_RNW_REST 1'b1
`define EBB_STRB_REST 1'b1
`define EBB_BURST_REST 1'b0

`endif

/* File: hw/ebb_sync.sv */
// Purpose: Two-flop synchroniser for pins from outside ref_clk
// Assumes: Each bit is an independent level
// Notes: Only the second flop is visible outside
module ebb_sync #(
  parameter int W = 1
)(
  // Clock and control
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic clk_en,
  // Data
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  initial
  begin
    if (W < 1) $error("ebb_sync: W must be at least 1");
  end

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_r; // First stage, read only by s2_r
      logic s2_r; // Second stage

      // Two flops per bit
      always_ff @(posedge ref_clk)
      begin
        if (!rstn)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end
        else if (clk_en)
        begin
          s1_r <= din[i];
          s2_r <= s1_r;
        end
      end
      assign dout[i] = s2_r;
    end
  endgenerate

endmodule : ebb_sync

/* File: hw/ebb_tmr_if.sv */
// Purpose: Link between access sequencer and ready timer
// Assumes: Both ends on ref_clk
// Notes: start and stop are one-cycle pulses
interface ebb_tmr_if;
  logic start;    // Strobe just went active
  logic stop;     // Strobe phase left
  logic rdy;      // Synchronised ready level
  logic rv_over;  // Ready-valid period passed without ready
  logic timeout;  // Maximum wait passed without ready

  // Sequencer side
  modport ctl (output start, output stop, output rdy,
               input rv_over, input timeout);
  // Timer side
  modport tmr (input start, input stop, input rdy,
               output rv_over, output timeout);
endinterface : ebb_tmr_if

/* File: tb/ebb_bridge_tb.sv */
// Purpose: Self-checking bench for the peripheral bus bridge
// Assumes: dev0 async, dev1 async mux, dev2 sync, dev3 16-bit matched
// Notes: Row table first, then FIFO and mid-access reset
module ebb_bridge_tb;
  import ebb_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic wr; logic [1:0] dev; logic [15:0] a; logic [31:0] d;
    logic [7:0] dl; logic [1:0] rs; logic [31:0] ex;
  } ebb_row_s;
  logic ref_clk = 1'b0, rstn = 1'b0, prh_clk = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 0, s_axi_rready = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, busy, late_ready, prh_rdy, prh_data_oe, prh_ads;
  logic prh_rnw, prh_rd_n, prh_wr_n, prh_burst;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] cfg_sync_mode = 4'h4, cfg_mux_mode = 4'h2;
  logic [3:0] cfg_width_match = 4'h8, prh_cs_n;
  logic [3:0][1:0] cfg_periph_width = {PW_16, PW_32, PW_32, PW_32};
  logic cfg_fifo_en = 1'b0;
  logic [15:0] cfg_fifo_addr = 16'h0080, prh_addr, last_addr;
  logic [0:31] prh_data_i, prh_data_o, last_wr;
  logic [0:3] periph_byte_enables;
  logic [7:0] dly = 8'h02;
  int bad_count = 0, cmp_count = 0;
  ebb_row_s r;
  ebb_row_s rows [8] = '{
    '{1'b1, 2'h0, 16'h0010, 32'h12345678, 8'h02, RESP_OKAY, 32'h12340010},
    '{1'b0, 2'h0, 16'h0020, 32'h0, 8'h05, RESP_OKAY, 32'h0020FFDF},
    '{1'b1, 2'h1, 16'h0030, 32'hCAFEF00D, 8'h01, RESP_OKAY, 32'hCAFE0030},
    '{1'b0, 2'h2, 16'h0044, 32'h0, 8'h00, RESP_OKAY, 32'h0044FFBB},
    '{1'b1, 2'h3, 16'h0040, 32'h89AB5678, 8'h01, RESP_OKAY, 32'h56780042},
    '{1'b0, 2'h3, 16'h0050, 32'h0, 8'h01, RESP_OKAY, 32'h00500052},
    '{1'b0, 2'h0, 16'h0070, 32'h0, 8'hFF, RESP_SLVERR, 32'h0},
    '{1'b1, 2'h2, 16'h0060, 32'h0BADBEEF, 8'h02, RESP_OKAY, 32'h0BAD0060}};
  ebb_bridge #(.NUM_DEV(4), .PA_WIDTH(16), .AD_WIDTH(32)) uut (.ref_clk,
    .rstn, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cfg_sync_mode, .cfg_mux_mode, .cfg_width_match,
    .cfg_periph_width, .cfg_fifo_en, .cfg_fifo_addr, .busy, .late_ready,
    .prh_clk, .prh_rst(1'b0), .prh_rdy, .prh_data_i, .prh_cs_n, .prh_addr,
    .prh_ads, .periph_byte_enables, .prh_rnw, .prh_rd_n, .prh_wr_n,
    .prh_burst, .prh_data_o, .prh_data_oe);
  ebb_periph_model pm (.ref_clk, .prh_cs_n, .sync_mode(cfg_sync_mode),
    .prh_addr, .prh_rnw, .prh_rd_n, .prh_wr_n, .prh_data_o, .prh_data_oe,
    .dly, .prh_rdy, .prh_data_i, .last_wr, .last_addr);
  initial forever #2 ref_clk = ~ref_clk;
  initial forever #62.5 prh_clk = ~prh_clk;
  // Compare one value and count it
  task automatic chk(input string nm, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One AXI transfer, held until each handshake edge
  task automatic xfer(input logic wr, input logic [31:0] a, d,
                      input logic [7:0] dl);
    int n;
    @(posedge ref_clk) #1;
    dly = dl;
    s_axi_awaddr = a;
    s_axi_araddr = a;
    s_axi_wdata = d;
    s_axi_awvalid = wr;
    s_axi_wvalid = wr;
    s_axi_arvalid = !wr;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    for (n = 0; n < 99 && !(s_axi_awready | s_axi_arready); n++)
      @(negedge ref_clk);
    chk("accept", 32'h1, {31'h0, s_axi_awready | s_axi_arready});
    @(posedge ref_clk) #1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_arvalid = 1'b0;
    for (n = 0; n < 2999 && !(s_axi_bvalid | s_axi_rvalid); n++)
      @(negedge ref_clk);
    chk("answer", 32'h1, {31'h0, s_axi_bvalid | s_axi_rvalid});
    rs = wr ? s_axi_bresp : s_axi_rresp;
    rd = s_axi_rdata;
    @(posedge ref_clk) #1;
    s_axi_bready = 1'b0;
    s_axi_rready = 1'b0;
  endtask : xfer
  // Print the verdict and stop
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    bad_count++;
    $display("[ERR] run expected end seen hang");
    conclude();
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      xfer(r.wr, {2'h0, r.dev, 12'h000, r.a}, r.d, r.dl);
      chk("resp", {30'h0, r.rs}, {30'h0, rs});
      if (r.rs == RESP_OKAY)
        chk("data", r.ex, r.wr ? {last_wr[0:15], last_addr} : rd);
      if (r.dl == 8'h05)
        chk("late", 32'h1, {31'h0, late_ready});
      $display("row %0d done", i);
    end
    cfg_fifo_en = 1'b1;
    xfer(1'b1, 32'h3000_0080, 32'h89AB5678, 8'h01);
    chk("fifo", 32'h56780080, {last_wr[0:15], last_addr});
    $display("fifo test done");
    s_axi_awaddr = 32'h0;
    s_axi_awvalid = 1'b1;
    s_axi_wvalid = 1'b1;
    dly = 8'hFF;
    repeat (7) @(posedge ref_clk);
    #1 chk("strobe", 32'h0, {31'h0, prh_wr_n});
    chk("be busy", 32'h1F, {27'h0, periph_byte_enables, busy});
    rstn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk("idle", 32'h1F, {prh_cs_n, prh_wr_n});
    rstn = 1'b1;
    xfer(1'b1, 32'h0000_0004, 32'h13572468, 8'h01);
    chk("after", 32'h13570004, {last_wr[0:15], last_addr});
    $display("reset test done");
    conclude();
  end
endmodule : ebb_bridge_tb

/* File: tb/ebb_checker.sv */
// Purpose: Pin protocol checks beside the bridge
// Assumes: One ref_clk domain, synchronous active-low reset
// Notes: Bound to ebb_bridge after the module
module ebb_checker #(
  parameter int NUM_DEV = 4
)(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Watched pins and config
  input wire logic [NUM_DEV-1:0] prh_cs_n,
  input wire logic [NUM_DEV-1:0] cfg_mux_mode,
  input wire logic prh_ads,
  input wire logic prh_rnw,
  input wire logic prh_rd_n,
  input wire logic prh_wr_n,
  input wire logic prh_burst,
  input wire logic prh_rdy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire strb_n = prh_rd_n & prh_wr_n;  // No strobe active
  logic [4:0] low_r;  // Cycles the strobe has been low
  logic seen_r;  // Ready seen while the strobe was low
  // Time the strobe and note ready
  always_ff @(posedge ref_clk)
  begin
    if (!rstn || strb_n)
    begin
      low_r <= 5'h00;
      seen_r <= 1'b0;
    end
    else
    begin
      low_r <= low_r + {4'h0, ~&low_r};
      seen_r <= seen_r | prh_rdy;
    end
  end
  // Strobe released
  sequence strb_end;
    $rose(strb_n);
  endsequence
  a_cs_reset_high: assert property ($rose(rstn) |-> &prh_cs_n)
    else $error("chip select active after reset");
  a_ads_reset_low: assert property ($rose(rstn) |-> !prh_ads)
    else $error("address strobe high after reset");
  a_rnw_reset_high: assert property ($rose(rstn) |-> prh_rnw)
    else $error("direction low after reset");
  a_strb_reset_high: assert property ($rose(rstn) |-> strb_n)
    else $error("read or write strobe low after reset");
  a_burst_reset_low: assert property ($rose(rstn) |-> !prh_burst)
    else $error("burst high after reset");
  a_ads_mux_only: assert property (prh_ads |-> |(cfg_mux_mode & ~prh_cs_n))
    else $error("address strobe on a separate-bus device");
  a_rnw_dir_match: assert property (!strb_n |-> prh_rnw == prh_wr_n)
    else $error("direction disagrees with strobe");
  a_end_after_ready: assert property (strb_end |-> seen_r || low_r >= 5'd11)
    else $error("strobe ended without ready or timeout");
  a_wait_bounded: assert property (low_r <= 5'd16)
    else $error("strobe held past the maximum wait");
endmodule : ebb_checker

bind ebb_bridge ebb_checker #(.NUM_DEV(NUM_DEV)) chk_i (.ref_clk, .rstn,
  .prh_cs_n, .cfg_mux_mode, .prh_ads, .prh_rnw, .prh_rd_n, .prh_wr_n,
  .prh_burst, .prh_rdy);

/* File: tb/ebb_periph_model.sv */
// Purpose: Behavioural peripheral on the far side of the bridge
// Assumes: Ready rises dly ref_clk cycles into an access
// Notes: dly of FF never answers, so the wait times out
module ebb_periph_model (
  // Clock
  input wire logic ref_clk,
  // Pins from the bridge
  input wire logic [3:0] prh_cs_n,
  input wire logic [3:0] sync_mode,
  input wire logic [15:0] prh_addr,
  input wire logic prh_rnw,
  input wire logic prh_rd_n,
  input wire logic prh_wr_n,
  input wire logic [0:31] prh_data_o,
  input wire logic prh_data_oe,
  // Answer control and capture
  input wire logic [7:0] dly,
  output logic prh_rdy,
  output logic [0:31] prh_data_i,
  output logic [0:31] last_wr,
  output logic [15:0] last_addr
);
  logic [7:0] cnt_r;  // Cycles into the access
  wire sel = ~&prh_cs_n;  // Some device selected
  wire sync = |(sync_mode & ~prh_cs_n);  // Selected one is synchronous
  wire act = sel && (sync || !prh_rd_n || !prh_wr_n);  // Access phase
  wire rd = sel && prh_rnw && !prh_data_oe;  // Read data wanted
  initial
  begin
    cnt_r = 8'h00;
    prh_rdy = 1'b0;
    prh_data_i = 32'h0000_0000;
  end
  // Ready after the delay, held until deselected; data toggles whenever no read is wanted
  always @(posedge ref_clk)
  begin
    cnt_r <= act ? cnt_r + {7'h00, ~&cnt_r} : 8'h00;
    prh_rdy <= dly == 8'h00 || (prh_rdy && sel) ||
               (act && cnt_r >= dly && dly != 8'hFF);
    prh_data_i <= rd ? {prh_addr, ~prh_addr} : ~prh_data_i;
    if (act && !prh_rnw)
    begin
      last_wr <= prh_data_o;
      last_addr <= prh_addr;
    end
  end
endmodule : ebb_periph_model
